/* File: src/cca_pkg.sv */
// shared constants, field layout and helpers for the channel assessment block
package cca_pkg;

   // timing: clock period and the averaging unit
   localparam int CCA_CLK_PERIOD_NS = 50;
   localparam int CCA_UNIT_NS       = 1000;
   localparam int CCA_TICK_CYCLES   = (CCA_UNIT_NS + CCA_CLK_PERIOD_NS - 1) / CCA_CLK_PERIOD_NS;
   localparam logic [4:0] CCA_TICK_LAST = 5'(CCA_TICK_CYCLES - 1);

   // bus widths
   localparam int CCA_ADDR_W = 16;
   localparam int CCA_DATA_W = 8;

   // register offsets (register index equals address on the plain port)
   localparam logic [15:0] CCA_CTRL_ADDR = 16'h2248;
   localparam logic [15:0] CCA_THR_ADDR  = 16'h2249;
   localparam logic [15:0] CCA_OFS_ADDR  = 16'h224a;
   localparam logic [15:0] CCA_STAT_ADDR = 16'h2250;
   localparam logic [15:0] CCA_AVG_ADDR  = 16'h2251;

   // control field positions
   localparam int CCA_WIN_MSB = 6;
   localparam int CCA_WIN_LSB = 4;
   localparam int CCA_FIX_BIT = 3;
   localparam int CCA_MTH_MSB = 1;
   localparam int CCA_MTH_LSB = 0;
   localparam int CCA_STAT_BUSY_BIT = 0;

   // reset values; reserved control bits are fixed at their reset level
   localparam logic [7:0] CCA_CTRL_RST     = 8'hc4;
   localparam logic [7:0] CCA_CTRL_RO_MASK = 8'h84;
   localparam logic [7:0] CCA_THR_RST      = 8'hb2;
   localparam logic [7:0] CCA_OFS_RST      = 8'h00;

   // averaging window limits
   localparam logic [2:0] CCA_MAX_LOG2 = 3'h4;
   localparam int         CCA_ACC_W    = 13;

   // assessment methods
   typedef enum logic [1:0] {
      CCA_ENERGY_DETECT  = 2'h0,
      CCA_CARRIER_DETECT = 2'h1,
      CCA_FRAME_DETECT   = 2'h2,
      CCA_METHOD_RSVD    = 2'h3
   } cca_method_type;

   // window code to log2 of the number of one-microsecond samples
   function automatic logic [2:0] ccaWinLog2(input logic [2:0] code);
      ccaWinLog2 = (code > 3'h3) ? CCA_MAX_LOG2 : code;
   endfunction

   // energy level in dBm: offset minus front-end gain
   function automatic logic signed [8:0] ccaEnergyLevel(input logic [7:0] ofs,
                                                        input logic [7:0] gain);
      ccaEnergyLevel = $signed({ofs[7], ofs}) - $signed({1'b0, gain});
   endfunction

endpackage

/* File: src/cca_us_tick.sv */
`timescale 1ns/1ps
`default_nettype none
// one-microsecond sample strobe from the system clock
module cca_us_tick (
   // clock and reset
   input  wire logic sys_clk,
   input  wire logic rst,
   input  wire logic ce,
   // strobe out
   output logic      usTick
);
   import cca_pkg::*;

   logic [4:0] cycleCnt_r;   // cycles into the current microsecond

   // free-running cycle counter, wraps once per microsecond
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cycleCnt_r <= 5'h00;
      end else if (ce) begin
         if (cycleCnt_r == CCA_TICK_LAST) begin
            cycleCnt_r <= 5'h00;
         end else begin
            cycleCnt_r <= cycleCnt_r + 5'h01;
         end
      end
   end

   // strobe in the last cycle of each microsecond
   assign usTick = ce && (cycleCnt_r == CCA_TICK_LAST);

endmodule
`default_nettype wire

/* File: src/cca_energy_avg.sv */
`timescale 1ns/1ps
`default_nettype none
// sums one energy sample per microsecond and averages over the window
module cca_energy_avg (
   // clock and reset
   input  wire logic              sys_clk,
   input  wire logic              rst,
   input  wire logic              ce,
   // samples
   input  wire logic              usTick,
   input  wire logic [2:0]        winLog2,
   input  wire logic signed [8:0] energyNow,
   // result
   output logic                   winEnd,
   output logic signed [8:0]      energyAvg
);
   import cca_pkg::*;

   logic signed [cca_pkg::CCA_ACC_W-1:0] acc_r;    // running sum
   logic [4:0]                           smpCnt_r; // samples taken so far
   logic signed [cca_pkg::CCA_ACC_W-1:0] accSum;   // sum including this sample
   logic [4:0]                           smpLast;  // last sample index

   // sum with the sample of this tick
   assign accSum  = acc_r + CCA_ACC_W'(energyNow);
   assign smpLast = 5'((5'h01 << winLog2) - 5'h01);
   // window closes on the last sample; a shortened window closes at the next tick
   assign winEnd  = usTick && (smpCnt_r >= smpLast);
   assign energyAvg = 9'(accSum >>> winLog2);

   // accumulate samples, restart after each window
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         acc_r    <= '0;
         smpCnt_r <= 5'h00;
      end else if (ce && usTick) begin
         if (winEnd) begin
            acc_r    <= '0;
            smpCnt_r <= 5'h00;
         end else begin
            acc_r    <= accSum;
            smpCnt_r <= smpCnt_r + 5'h01;
         end
      end
   end

endmodule
`default_nettype wire

/* File: src/cca_core.sv */
// How it works
// - window field picks 1 to 16 us average
// - busy channel holds back pending packet
// - force-idle bit always permits transmission
// - method field picks energy, carrier, frame
// - energy method: busy when average above threshold
// - carrier method: busy on modulated signal
// - frame method: busy only on packet
// - threshold register holds busy energy level
// - threshold used only by energy method
// - threshold is signed dBm
// - threshold resets to minus 78 dBm
// - energy from gain plus offset register
// - energy equals offset minus gain
//
// Our own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module cca_core (
   // clock, reset and enable
   input  wire logic                          sys_clk,
   input  wire logic                          rst,
   input  wire logic                          ce,
   // register port
   input  wire logic [cca_pkg::CCA_ADDR_W-1:0] regAddr,
   input  wire logic [cca_pkg::CCA_DATA_W-1:0] regWrData,
   input  wire logic                          regWrEn,
   input  wire logic                          regRdEn,
   output logic      [cca_pkg::CCA_DATA_W-1:0] regRdData,
   // receive front end
   input  wire logic [7:0]                    frontEndGain,
   input  wire logic                          carrierDetect,
   input  wire logic                          frameDetect,
   // transmit sequencer
   input  wire logic                          txPending,
   output logic                               txPermit,
   output logic                               channelBusy
);
   import cca_pkg::*;

   // software registers
   logic [7:0]        assessmentControl_r;   // window, force idle, method
   logic [7:0]        busyThreshold_r;       // signed dBm threshold
   logic [7:0]        energyOffset_r;        // calibration offset
   // outputs held in flip-flops
   logic [7:0]        regRdData_r;           // read data, one cycle later
   logic              channelBusy_r;         // decision of last window
   logic              txPermit_r;            // permit to the sequencer
   // detector latches over the current window
   logic              carrierSeen_r;         // carrier seen this window
   logic              frameSeen_r;           // packet seen this window
   // last finished average, for readback
   logic signed [8:0] lastAvg_r;
   // decoded fields and datapath
   logic [2:0]        energy_average_window; // window code
   logic              force_channel_idle;    // override bit
   cca_method_type    assessment_method_select;
   logic [2:0]        winLog2;               // log2 of samples per window
   logic              usTick;                // one-microsecond strobe
   logic              winEnd;                // last sample of the window
   logic signed [8:0] energyNow;             // current energy in dBm
   logic signed [8:0] energyAvg;             // window average in dBm
   logic signed [8:0] thresholdExt;          // threshold widened
   logic              busy_nxt;              // decision at window end
   logic              txPermit_nxt;          // next permit
   logic [7:0]        rdMux;                 // selected read value

   // field decode
   assign energy_average_window    = assessmentControl_r[CCA_WIN_MSB:CCA_WIN_LSB];
   assign force_channel_idle       = assessmentControl_r[CCA_FIX_BIT];
   assign assessment_method_select = cca_method_type'(assessmentControl_r[CCA_MTH_MSB:CCA_MTH_LSB]);
   assign winLog2 = ccaWinLog2(energy_average_window);

   assign thresholdExt = $signed({busyThreshold_r[7], busyThreshold_r});
   assign energyNow = ccaEnergyLevel(energyOffset_r, frontEndGain);

   // microsecond strobe
   cca_us_tick u_tick (
      .sys_clk (sys_clk),
      .rst     (rst),
      .ce      (ce),
      .usTick  (usTick)
   );

   // averaging over the window
   cca_energy_avg u_avg (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .ce        (ce),
      .usTick    (usTick),
      .winLog2   (winLog2),
      .energyNow (energyNow),
      .winEnd    (winEnd),
      .energyAvg (energyAvg)
   );

   // control register write; reserved bits keep their fixed level
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         assessmentControl_r <= CCA_CTRL_RST;
      end else if (ce && regWrEn && (regAddr == CCA_CTRL_ADDR)) begin
         assessmentControl_r <= (regWrData & ~CCA_CTRL_RO_MASK) | (CCA_CTRL_RST & CCA_CTRL_RO_MASK);
      end
   end

   // threshold register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         busyThreshold_r <= CCA_THR_RST;
      end else if (ce && regWrEn && (regAddr == CCA_THR_ADDR)) begin
         busyThreshold_r <= regWrData;
      end
   end

   // energy offset register
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         energyOffset_r <= CCA_OFS_RST;
      end else if (ce && regWrEn && (regAddr == CCA_OFS_ADDR)) begin
         energyOffset_r <= regWrData;
      end
   end

   // read mux; unmapped addresses read zero
   always_comb begin
      unique case (regAddr)
         CCA_CTRL_ADDR: rdMux = assessmentControl_r;
         CCA_THR_ADDR:  rdMux = busyThreshold_r;
         CCA_OFS_ADDR:  rdMux = energyOffset_r;
         CCA_STAT_ADDR: rdMux = {7'h00, channelBusy_r};
         CCA_AVG_ADDR:  rdMux = lastAvg_r[7:0];
         default:       rdMux = 8'h00;
      endcase
   end

   // read data stands only in the cycle after the strobe
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         regRdData_r <= 8'h00;
      end else if (ce) begin
         if (regRdEn) begin
            regRdData_r <= rdMux;
         end else begin
            regRdData_r <= 8'h00;
         end
      end
   end

   // carrier latch; a detection at window end is not lost
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         carrierSeen_r <= 1'b0;
      end else if (ce) begin
         if (winEnd) begin
            carrierSeen_r <= 1'b0;
         end else if (carrierDetect) begin
            carrierSeen_r <= 1'b1;
         end
      end
   end

   // packet latch, same scheme as the carrier latch
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         frameSeen_r <= 1'b0;
      end else if (ce) begin
         if (winEnd) begin
            frameSeen_r <= 1'b0;
         end else if (frameDetect) begin
            frameSeen_r <= 1'b1;
         end
      end
   end

   // decision for the window now ending
   always_comb begin
      unique case (assessment_method_select)
         CCA_ENERGY_DETECT:  busy_nxt = (energyAvg > thresholdExt);
         CCA_CARRIER_DETECT: busy_nxt = carrierSeen_r | carrierDetect;
         CCA_FRAME_DETECT:   busy_nxt = frameSeen_r | frameDetect;
         // reserved code leaves the channel idle
         CCA_METHOD_RSVD:    busy_nxt = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         channelBusy_r <= 1'b0;
         lastAvg_r     <= '0;
      end else if (ce && winEnd) begin
         channelBusy_r <= busy_nxt;
         lastAvg_r     <= energyAvg;
      end
   end

   assign txPermit_nxt = txPending && (!channelBusy_r || force_channel_idle);

   // permit register toward the sequencer
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         txPermit_r <= 1'b0;
      end else if (ce) begin
         txPermit_r <= txPermit_nxt;
      end
   end

   // outputs straight from flip-flops
   assign regRdData   = regRdData_r;
   assign txPermit    = txPermit_r;
   assign channelBusy = channelBusy_r;

   // checking helpers: microsecond ticks since the last window end
   logic [4:0] tickSince_r;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         tickSince_r <= 5'h00;
      end else if (ce && usTick) begin
         if (winEnd) begin
            tickSince_r <= 5'h00;
         end else begin
            tickSince_r <= tickSince_r + 5'h01;
         end
      end
   end

   // helper: no control register write since the last window end
   logic winStable_r;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         winStable_r <= 1'b1;
      end else if (ce) begin
         if (winEnd) begin
            winStable_r <= 1'b1;
         end else if (regWrEn && (regAddr == CCA_CTRL_ADDR)) begin
            winStable_r <= 1'b0;
         end
      end
   end

   // helper: enabled cycles since the last microsecond strobe, counted apart from the tick counter
   logic [4:0] gapCnt_r;
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         gapCnt_r <= 5'h00;
      end else if (ce) begin
         if (usTick) begin
            gapCnt_r <= 5'h00;
         end else begin
            gapCnt_r <= gapCnt_r + 5'h01;
         end
      end
   end

   win_length_a: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && winEnd && winStable_r && (tickSince_r != 5'h00))
      |-> (6'(tickSince_r) + 6'h01) == (6'h01 << winLog2))
      else $error("window closed after wrong number of samples");

   tick_spacing_a: assert property (@(posedge sys_clk) disable iff (rst)
      ce |-> (usTick == (gapCnt_r == CCA_TICK_LAST)))
      else $error("microsecond strobe not 20 cycles apart");

   tx_blocked_a: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && channelBusy_r && !force_channel_idle) |=> !txPermit_r)
      else $error("permit given on busy channel");

   force_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && force_channel_idle && txPending) |=> txPermit_r)
      else $error("force idle did not permit transmission");

   ed_decide_a: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && winEnd && (assessment_method_select == CCA_ENERGY_DETECT))
      |=> channelBusy_r == ($past(energyAvg) > $past(thresholdExt)))
      else $error("energy decision disagrees with threshold");

   cd_decide_a: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && winEnd && (assessment_method_select == CCA_CARRIER_DETECT) && carrierDetect)
      |=> channelBusy_r)
      else $error("carrier seen but channel idle");

   fd_decide_a: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && winEnd && (assessment_method_select == CCA_FRAME_DETECT)
       && !frameSeen_r && !frameDetect) |=> !channelBusy_r)
      else $error("busy without a detected packet");

   rsvd_method_a: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && winEnd && (assessment_method_select == CCA_METHOD_RSVD)) |=> !channelBusy_r)
      else $error("reserved method produced busy");

   thr_write_a: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && regWrEn && (regAddr == CCA_THR_ADDR)) |=> busyThreshold_r == $past(regWrData))
      else $error("threshold write not stored");

   energy_calc_a: assert property (@(posedge sys_clk) disable iff (rst)
      energyNow == 9'(int'($signed(energyOffset_r)) - int'(frontEndGain)))
      else $error("energy level not offset minus gain");

   busy_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
      !(ce && winEnd) |=> $stable(channelBusy_r))
      else $error("decision changed outside window end");

   // read data stands one cycle only
   rd_pulse_a: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && !regRdEn) |=> regRdData_r == 8'h00)
      else $error("read data outside read slot");

   cd_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && winEnd && (assessment_method_select == CCA_CARRIER_DETECT)
       && !carrierSeen_r && !carrierDetect) |=> !channelBusy_r)
      else $error("busy without a carrier");

   ofs_write_a: assert property (@(posedge sys_clk) disable iff (rst)
      (ce && regWrEn && (regAddr == CCA_OFS_ADDR)) |=> energyOffset_r == $past(regWrData))
      else $error("offset write not stored");

   // enable low freezes registers and decision
   ce_freeze_a: assert property (@(posedge sys_clk) disable iff (rst)
      !ce |=> ($stable(busyThreshold_r) && $stable(assessmentControl_r) && $stable(channelBusy_r)))
      else $error("state changed while enable low");

endmodule
`default_nettype wire

/* File: bench/cca_far_side.sv */
`timescale 1ns/1ps
`default_nettype none
// far side: receive front end and transmit sequencer
module cca_far_side (
   // clock and reset
   input  wire logic       sys_clk,
   input  wire logic       rst,
   // scenario controls
   input  wire logic [7:0] gainSet,
   input  wire logic       carrierOn,
   input  wire logic       frameOn,
   input  wire logic       pendOn,
   // toward the block
   output logic      [7:0] frontEndGain,
   output logic            carrierDetect,
   output logic            frameDetect,
   output logic            txPending
);
   logic [2:0] pulseCnt_r; // spacing of detector pulses

   // free count that places short detector pulses
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pulseCnt_r <= 3'h0;
      end else begin
         pulseCnt_r <= pulseCnt_r + 3'h1;
      end
   end

   // gain follows the scenario at once
   assign frontEndGain  = gainSet;
   // detectors give one-cycle pulses, never a steady level
   assign carrierDetect = carrierOn & (pulseCnt_r == 3'h5);
   assign frameDetect   = frameOn & (pulseCnt_r == 3'h2);
   // a packet waits as long as the scenario says
   assign txPending     = pendOn;
endmodule
`default_nettype wire

/* File: bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the channel assessment core
module tb;
   import cca_pkg::*;
   // one ordinary case: settings and the outputs they should give
   typedef struct {
      logic [7:0] ctrl, thr, ofs, gain;
      logic       car, frm, pend, chkBusy, expBusy, expPermit;
   } cca_row_type;

   logic        sys_clk;      // system clock
   logic        rst;          // reset, active high
   logic [15:0] regAddr;      // register address
   logic [7:0]  regWrData;    // write data
   logic        regWrEn;      // write strobe
   logic        regRdEn;      // read strobe
   logic [7:0]  regRdData;    // read data
   logic [7:0]  frontEndGain; // gain from far side
   logic        carrierDetect;
   logic        frameDetect;
   logic        txPending;
   logic        txPermit;
   logic        channelBusy;
   logic [7:0]  gainSet;      // far side controls
   logic        carrierOn;
   logic        frameOn;
   logic        pendOn;
   logic        ce;           // clock enable to the block
   int          n_mismatch = 0;
   int          num_checks = 0;

   // ctrl, thr, ofs, gain, car, frm, pend, chkBusy, busy, permit
   cca_row_type rows [13] = '{
      '{8'h00, 8'hb2, 8'h00, 8'h32, 0, 0, 1, 1, 1, 0},
      '{8'h00, 8'hb2, 8'h00, 8'h64, 0, 0, 1, 1, 0, 1},
      '{8'h00, 8'hce, 8'h00, 8'h31, 0, 0, 1, 1, 1, 0},
      '{8'h00, 8'hce, 8'h00, 8'h32, 0, 0, 1, 1, 0, 1},
      '{8'h00, 8'hb2, 8'h14, 8'h62, 0, 0, 1, 1, 0, 1},
      '{8'h00, 8'hb2, 8'h14, 8'h61, 0, 0, 1, 1, 1, 0},
      '{8'h01, 8'hb2, 8'h00, 8'h00, 1, 0, 1, 1, 1, 0},
      '{8'h01, 8'hb2, 8'h00, 8'h00, 0, 1, 1, 1, 0, 1},
      '{8'h02, 8'hb2, 8'h00, 8'h00, 0, 1, 1, 1, 1, 0},
      '{8'h02, 8'hb2, 8'h00, 8'h00, 1, 0, 1, 1, 0, 1},
      '{8'h03, 8'hb2, 8'h00, 8'h00, 1, 1, 1, 1, 0, 1},
      '{8'h08, 8'hb2, 8'h00, 8'h32, 0, 0, 1, 1, 1, 1},
      '{8'h00, 8'hb2, 8'h00, 8'h64, 0, 0, 0, 1, 0, 0}
   };

   // clock generator
   initial begin
      sys_clk = 1'b0;
      forever #(CCA_CLK_PERIOD_NS / 2) sys_clk = ~sys_clk;
   end

   // block under test
   cca_core DUT (
      .sys_clk(sys_clk), .rst(rst), .ce(ce),
      .regAddr(regAddr), .regWrData(regWrData), .regWrEn(regWrEn),
      .regRdEn(regRdEn), .regRdData(regRdData),
      .frontEndGain(frontEndGain), .carrierDetect(carrierDetect),
      .frameDetect(frameDetect), .txPending(txPending),
      .txPermit(txPermit), .channelBusy(channelBusy)
   );

   // model of the far side
   cca_far_side far (
      .sys_clk(sys_clk), .rst(rst), .gainSet(gainSet), .carrierOn(carrierOn),
      .frameOn(frameOn), .pendOn(pendOn), .frontEndGain(frontEndGain),
      .carrierDetect(carrierDetect), .frameDetect(frameDetect), .txPending(txPending)
   );

   // compare and count
   task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // one-cycle register write
   task automatic regWr(input logic [15:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      regWrEn   <= 1'b1;
      regAddr   <= a;
      regWrData <= d;
      @(posedge sys_clk);
      regWrEn <= 1'b0;
   endtask

   // one-cycle register read, data taken in the following cycle
   task automatic regRd(input logic [15:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      regRdEn <= 1'b1;
      regAddr <= a;
      @(posedge sys_clk);
      regRdEn <= 1'b0;
      #1 d = regRdData;
   endtask

   // let some cycles pass, ending just after an edge
   task automatic waitCycles(input int k);
      repeat (k) @(posedge sys_clk);
      #1;
   endtask

   // wait a bounded time for a given channel state
   task automatic waitBusy(input logic lvl, input int lim, output int n);
      n = 0;
      while (channelBusy !== lvl && n < lim) begin
         @(posedge sys_clk);
         #1 n++;
      end
      check("busy level", 16'(lvl), 16'(channelBusy));
   endtask

   // verdict and end of run
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // main sequence
   initial begin
      logic [7:0] d;
      int         n;
      int         w;
      rst       = 1'b1;
      regAddr   = 16'h0000;
      regWrData = 8'h00;
      regWrEn   = 1'b0;
      regRdEn   = 1'b0;
      gainSet   = 8'h64;
      carrierOn = 1'b0;
      frameOn   = 1'b0;
      pendOn    = 1'b0;
      ce        = 1'b1;
      repeat (20) @(posedge sys_clk);
      rst <= 1'b0;
      // ordinary cases with the shortest window
      foreach (rows[i]) begin
         @(posedge sys_clk);
         gainSet   <= rows[i].gain;
         carrierOn <= rows[i].car;
         frameOn   <= rows[i].frm;
         pendOn    <= rows[i].pend;
         regWr(CCA_THR_ADDR, rows[i].thr);
         regWr(CCA_OFS_ADDR, rows[i].ofs);
         regWr(CCA_CTRL_ADDR, rows[i].ctrl);
         waitCycles(100);
         if (rows[i].chkBusy) begin
            check("channelBusy", 16'(rows[i].expBusy), 16'(channelBusy));
            regRd(CCA_STAT_ADDR, d);
            check("status", 16'(rows[i].expBusy), 16'(d & 8'h01));
         end
         check("txPermit", 16'(rows[i].expPermit), 16'(txPermit));
         $display("row %0d done", i);
      end
      // reset in mid-run while busy and permitted by force idle
      @(posedge sys_clk);
      gainSet <= 8'h32;
      pendOn  <= 1'b1;
      regWr(CCA_CTRL_ADDR, 8'h08);
      waitCycles(100);
      check("busy before reset", 16'h1, 16'(channelBusy));
      check("permit before reset", 16'h1, 16'(txPermit));
      @(posedge sys_clk);
      rst <= 1'b1;
      #1 check("busy in reset", 16'h0, 16'(channelBusy));
      check("permit in reset", 16'h0, 16'(txPermit));
      repeat (3) @(posedge sys_clk);
      rst <= 1'b0;
      regRd(CCA_CTRL_ADDR, d);
      check("ctrl reset", 16'h00c4, 16'(d));
      waitCycles(1);
      check("read stands one cycle", 16'h0, 16'(regRdData));
      regRd(CCA_THR_ADDR, d);
      check("thr reset", 16'h00b2, 16'(d));
      regRd(CCA_OFS_ADDR, d);
      check("ofs reset", 16'(CCA_OFS_RST), 16'(d));
      regWr(16'h224c, 8'hff);
      regRd(16'h224c, d);
      check("unmapped", 16'h0, 16'(d));
      regWr(CCA_CTRL_ADDR, 8'h00);
      regRd(CCA_CTRL_ADDR, d);
      check("ctrl fixed bits", 16'h0084, 16'(d));
      regWr(CCA_THR_ADDR, 8'h5a);
      regRd(CCA_THR_ADDR, d);
      check("thr write", 16'h005a, 16'(d));
      $display("reset and map test done");
      // window length per code, measured between two decisions
      regWr(CCA_THR_ADDR, 8'hb2);
      for (int c = 0; c < 8; c++) begin
         w = 20 << ((c > 3) ? 4 : c);
         @(posedge sys_clk);
         gainSet <= 8'h64;
         regWr(CCA_CTRL_ADDR, {1'b0, 3'(c), 4'h0});
         waitBusy(1'b0, 2 * w + 60, n);
         @(posedge sys_clk);
         gainSet <= 8'h32;
         waitBusy(1'b1, 2 * w + 60, n);
         @(posedge sys_clk);
         gainSet <= 8'h64;
         #1 waitBusy(1'b0, 2 * w + 60, n);
         check("window cycles", 16'(w), 16'(n + 1));
         $display("window code %0d done", c);
      end
      // enable low freezes decision and registers
      @(posedge sys_clk);
      ce      <= 1'b0;
      gainSet <= 8'h32;
      regWr(CCA_THR_ADDR, 8'h00);
      waitCycles(700);
      check("frozen busy", 16'h0, 16'(channelBusy));
      @(posedge sys_clk);
      ce <= 1'b1;
      regRd(CCA_THR_ADDR, d);
      check("frozen thr", 16'h00b2, 16'(d));
      waitBusy(1'b1, 700, n);
      $display("enable test done");
      wrap_up();
   end

   // watchdog against a hang
   initial begin
      #(30000 * CCA_CLK_PERIOD_NS);
      n_mismatch++;
      $display("BAD watchdog expected finish seen hang");
      wrap_up();
   end
endmodule
`default_nettype wire
